// file: csi_contour_interp.sv
// Behaviour
// - Any nonzero set of up to eight axes may be selected, each following its own increments.
// - Unselected axes are never moved by this block and stay free for other modes.
// - A segment lasts two to the power of its interval code milliseconds, code 1 to 8.
// - Each millisecond every selected axis gets a new linearly interpolated position.
// - Interval code zero with zero increments ends contouring.
// - A record asking to wait blocks the next record until its segment has fully elapsed.
// - With contouring active and no record queued, positions hold and no points are made.
// - A bad record is dropped and answered with a question mark.
// - A record without a new code reuses the last code.
// - Segments keep running for as long as records arrive, with no count limit.
`timescale 1ns/1ps
module csi_contour_interp #(
    parameter int unsigned TICK_CYCLES = csi_pkg::TICK_CYCLES
) (
    input wire logic mclk_in,
    input wire logic rst_in,
    input wire logic rec_valid_in,
    input wire csi_pkg::csi_rec_s rec_in,
    output logic rec_ready_out,
    output logic resp_valid_out,
    output logic [7:0] resp_char_out,
    output logic contour_active_out,
    output logic [csi_pkg::AXES-1:0] contour_axis_select_out,
    output logic point_valid_out,
    output logic seg_done_out,
    output csi_pkg::csi_pos_t [csi_pkg::AXES-1:0] axis_pos_out
);

    csi_pkg::csi_state_s st_q;
    csi_pkg::csi_state_s st_d;
    logic take;
    logic bad;
    logic push;
    logic pop;
    logic range_bad;
    logic any_nz;
    logic seg_end;
    logic exact_ok;
    logic [csi_pkg::CODE_W-1:0] eff_code;
    logic [csi_pkg::AXES-1:0] eff_sel;
    logic [csi_pkg::AXES-1:0] moved;
    logic [csi_pkg::CNT_W-1:0] seg_len;
    csi_pkg::csi_sum_t acc;
    csi_pkg::csi_seg_s head;

    ////////////////////////////////////////////////////////////////////////
    always_comb
    begin
        st_d = st_q;
        take = 1'b0;
        bad = 1'b0;
        push = 1'b0;
        pop = 1'b0;
        range_bad = 1'b0;
        any_nz = 1'b0;
        seg_end = 1'b0;
        exact_ok = 1'b1;
        moved = '0;
        acc = '0;
        head = st_q.buf_mem[st_q.rd_ptr];
        seg_len = csi_pkg::CNT_W'(1) << st_q.cur.code;
        st_d.tick = 1'b0;
        st_d.point = 1'b0;
        st_d.seg_done = 1'b0;
        st_d.resp_valid = 1'b0;

        // Millisecond enable
        if (st_q.div == csi_pkg::DIV_W'(TICK_CYCLES - 1))
        begin
            st_d.div = '0;
            st_d.tick = 1'b1;
        end
        else
        begin
            st_d.div = st_q.div + 1'b1;
        end

        if (st_q.eng == csi_pkg::CSI_RUN && st_q.tick)
        begin
            st_d.point = 1'b1;
            st_d.k = st_q.k + 1'b1;
            seg_end = (st_q.k + 1'b1) == seg_len;
            for (int i = 0; i < csi_pkg::AXES; i++)
            begin
                if (st_q.axis_sel[i])
                begin
                    acc = st_q.sum[i] + csi_pkg::SUM_W'(st_q.cur.incr[i]);
                    st_d.sum[i] = acc;
                    st_d.pos[i] = st_q.base[i] + csi_pkg::POS_W'(acc >>> st_q.cur.code);
                    if (seg_end)
                    begin
                        if (acc != (csi_pkg::SUM_W'(st_q.cur.incr[i]) <<< st_q.cur.code))
                        begin
                            exact_ok = 1'b0;
                        end
                        st_d.base[i] = st_q.base[i] + csi_pkg::POS_W'(st_q.cur.incr[i]);
                        st_d.pos[i] = st_d.base[i];
                        st_d.sum[i] = '0;
                    end
                end
            end
            if (seg_end)
            begin
                st_d.seg_done = 1'b1;
                st_d.eng = csi_pkg::CSI_IDLE;
                st_d.k = '0;
                if (st_q.cur.wait_done)
                begin
                    st_d.wait_blk = 1'b0;
                end
            end
        end

        // Next segment loads in the ending cycle
        if (st_d.eng == csi_pkg::CSI_IDLE && st_q.cnt != 2'h0)
        begin
            pop = 1'b1;
            st_d.cur = head;
            st_d.rd_ptr = ~st_q.rd_ptr;
            st_d.k = '0;
            if (head.is_exit)
            begin
                st_d.active = 1'b0;
                st_d.axis_sel = '0;
                st_d.wait_blk = 1'b0;
            end
            else
            begin
                st_d.eng = csi_pkg::CSI_RUN;
            end
        end

        // Record intake and checks
        take = rec_valid_in & st_q.ready;
        eff_code = rec_in.code_load ? rec_in.code : st_q.last_code;
        eff_sel = rec_in.sel_load ? rec_in.axis_sel : st_q.axis_sel;
        for (int i = 0; i < csi_pkg::AXES; i++)
        begin
            if (eff_sel[i])
            begin
                if (rec_in.incr[i] > csi_pkg::INCR_LIMIT || rec_in.incr[i] < -csi_pkg::INCR_LIMIT)
                begin
                    range_bad = 1'b1;
                end
                if (rec_in.incr[i] != '0)
                begin
                    any_nz = 1'b1;
                end
            end
        end
        bad = (eff_sel == '0) || (eff_code > csi_pkg::CODE_MAX) || range_bad
            || (eff_code == csi_pkg::CODE_EXIT && any_nz);
        if (take)
        begin
            if (bad)
            begin
                st_d.resp_valid = 1'b1;
                st_d.resp_char = csi_pkg::ERR_CHAR;
            end
            else
            begin
                push = 1'b1;
                st_d.last_code = eff_code;
                st_d.axis_sel = eff_sel;
                st_d.active = 1'b1;
                st_d.buf_mem[st_q.wr_ptr].is_exit = (eff_code == csi_pkg::CODE_EXIT);
                st_d.buf_mem[st_q.wr_ptr].wait_done = rec_in.wait_done;
                st_d.buf_mem[st_q.wr_ptr].code = eff_code;
                st_d.buf_mem[st_q.wr_ptr].incr = rec_in.incr;
                st_d.wr_ptr = ~st_q.wr_ptr;
                // Block intake until done; set wins
                if (rec_in.wait_done)
                begin
                    st_d.wait_blk = 1'b1;
                end
            end
        end

        // Two-entry buffer occupancy and back-pressure
        if (push && !pop)
        begin
            st_d.cnt = st_q.cnt + 1'b1;
        end
        else if (pop && !push)
        begin
            st_d.cnt = st_q.cnt - 1'b1;
        end
        st_d.ready = (st_d.cnt < csi_pkg::BUF_DEPTH) && !st_d.wait_blk;

        for (int i = 0; i < csi_pkg::AXES; i++)
        begin
            moved[i] = st_d.pos[i] != st_q.pos[i];
        end
    end

    always_ff @(posedge mclk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            st_q <= '0;
        end
        else
        begin
            st_q <= st_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    assign rec_ready_out = st_q.ready;
    assign resp_valid_out = st_q.resp_valid;
    assign resp_char_out = st_q.resp_char;
    assign contour_active_out = st_q.active;
    assign contour_axis_select_out = st_q.axis_sel;
    assign point_valid_out = st_q.point;
    assign seg_done_out = st_q.seg_done;
    assign axis_pos_out = st_q.pos;

    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge mclk_in);
    endclocking
    default disable iff (rst_in);

    sequence s_good_wait;
        take && !bad && rec_in.wait_done;
    endsequence

    sequence s_exit_pop;
        pop && head.is_exit && !(take && !bad);
    endsequence

    sequence s_end_with_next;
        seg_end && st_q.cnt != 2'h0 && !head.is_exit;
    endsequence

    chk_sel_nonzero: assert property (contour_active_out |-> contour_axis_select_out != '0)
        else $error("contour active with no axis selected");

    chk_unsel_hold: assert property ((moved & ~st_q.axis_sel) == '0)
        else $error("unselected axis position changed");

    chk_seg_length: assert property (seg_done_out |-> $past(st_q.k) + 1'b1 == $past(seg_len))
        else $error("segment ended at wrong tick count");

    chk_point_tick: assert property (point_valid_out |-> $past(st_q.tick) && $past(st_q.eng) == csi_pkg::CSI_RUN)
        else $error("point without running tick");

    chk_exit_mode: assert property (s_exit_pop |=> !contour_active_out && contour_axis_select_out == '0)
        else $error("exit record did not end contouring");

    chk_wait_block: assert property (s_good_wait |=> !rec_ready_out)
        else $error("intake open right after a waiting record");

    // Wait lifts only at segment end or when an exit record is popped
    chk_wait_release: assert property ($fell(st_q.wait_blk) |-> seg_done_out || !contour_active_out)
        else $error("wait released before its segment ended");

    chk_exit_still: assert property (!contour_active_out |=> !point_valid_out)
        else $error("point made while not contouring");

    chk_hold_idle: assert property (st_q.eng == csi_pkg::CSI_IDLE |=> !point_valid_out && $stable(axis_pos_out))
        else $error("motion while no segment running");

    chk_bad_resp: assert property (take && bad |=> resp_valid_out && resp_char_out == csi_pkg::ERR_CHAR)
        else $error("bad record not answered with question mark");

    // Answer only for a bad record
    chk_resp_only_bad: assert property (!(take && bad) |=> !resp_valid_out)
        else $error("answer without a bad record");

    chk_code_keep: assert property (take && !bad && !rec_in.code_load |=> $stable(st_q.last_code))
        else $error("interval code changed without a new code");

    chk_exact_sum: assert property (seg_end |-> exact_ok)
        else $error("interpolated steps do not sum to increment");

    chk_back_to_back: assert property (s_end_with_next |=> st_q.eng == csi_pkg::CSI_RUN && st_q.k == '0)
        else $error("queued segment did not start at once");

endmodule : csi_contour_interp

// file: csi_pkg.sv
package csi_pkg;
    localparam int AXES = 8;
    localparam int INCR_W = 16;
    localparam int SUM_W = 25;
    localparam int POS_W = 32;
    localparam int CODE_W = 4;
    localparam int CNT_W = 9;
    localparam int DIV_W = 15;
    localparam int CLK_PERIOD_NS = 40;
    localparam int TICK_TIME_MS = 1;
    localparam int TICK_CYCLES = (TICK_TIME_MS * 1000000) / CLK_PERIOD_NS;
    localparam logic signed [INCR_W-1:0] INCR_LIMIT = 16'sh7D00;
    localparam logic [CODE_W-1:0] CODE_EXIT = 4'h0;
    localparam logic [CODE_W-1:0] CODE_MAX = 4'h8;
    localparam logic [CODE_W-1:0] CODE_RST = 4'h0;
    localparam logic [7:0] ERR_CHAR = 8'h3F;
    localparam logic [1:0] BUF_DEPTH = 2'h2;

    typedef enum logic [0:0] {CSI_IDLE = 1'b0, CSI_RUN = 1'b1} csi_eng_e;
    typedef logic signed [INCR_W-1:0] csi_incr_t;
    typedef logic signed [SUM_W-1:0] csi_sum_t;
    typedef logic signed [POS_W-1:0] csi_pos_t;

    typedef struct packed {
        logic sel_load;
        logic [AXES-1:0] axis_sel;
        logic code_load;
        logic [CODE_W-1:0] code;
        logic wait_done;
        csi_incr_t [AXES-1:0] incr;
    } csi_rec_s;

    typedef struct packed {
        logic is_exit;
        logic wait_done;
        logic [CODE_W-1:0] code;
        csi_incr_t [AXES-1:0] incr;
    } csi_seg_s;

    typedef struct packed {
        logic [DIV_W-1:0] div;
        logic tick;
        csi_seg_s [1:0] buf_mem;
        logic wr_ptr;
        logic rd_ptr;
        logic [1:0] cnt;
        logic ready;
        logic wait_blk;
        logic [CODE_W-1:0] last_code;
        logic active;
        logic [AXES-1:0] axis_sel;
        csi_eng_e eng;
        csi_seg_s cur;
        logic [CNT_W-1:0] k;
        csi_pos_t [AXES-1:0] base;
        csi_pos_t [AXES-1:0] pos;
        csi_sum_t [AXES-1:0] sum;
        logic point;
        logic seg_done;
        logic resp_valid;
        logic [7:0] resp_char;
    } csi_state_s;
endpackage : csi_pkg

// file: csi_src_model.sv
`timescale 1ns/1ps
module csi_src_model (
    input wire logic mclk_in,
    input wire logic rec_ready_in,
    output logic rec_valid_out,
    output csi_pkg::csi_rec_s rec_out
);
    initial
    begin
        rec_valid_out = 1'b0;
        rec_out = '0;
    end

    ////////////////////////////////////////////////////////////
    // record offered as built
    task automatic send(input csi_pkg::csi_rec_s r, input int gap);
        repeat (gap) @(negedge mclk_in);
        rec_out = r;
        rec_valid_out = 1'b1;
        while (rec_ready_in !== 1'b1) @(negedge mclk_in);
        @(negedge mclk_in);
        rec_valid_out = 1'b0;
        rec_out = ~r;
    endtask : send
endmodule : csi_src_model

// file: csi_contour_interp_tb.sv
`timescale 1ns/1ps
module csi_contour_interp_tb;
    localparam int TICKS = 4;
    typedef struct {logic [7:0] sel; logic cl; int code; logic wt; int a0; int a1;} csi_row_s;
    logic mclk_in = 1'b0;
    logic rst_in = 1'b1;
    logic rec_valid, rec_ready_out, resp_valid_out, contour_active_out, point_valid_out, seg_done_out;
    logic [7:0] resp_char_out, contour_axis_select_out;
    csi_pkg::csi_rec_s rec;
    csi_pkg::csi_pos_t [csi_pkg::AXES-1:0] axis_pos_out;
    csi_row_s rows[9];
    csi_row_s segq[$];
    csi_row_s cur;
    int base[8];
    int fails = 0, checked = 0, gap = 0, pts = 0, streak = 0, j = 0, cyc = 0, lc = 0, n = 0;

    initial
    begin
        forever #20 mclk_in = ~mclk_in;
    end

    csi_contour_interp #(.TICK_CYCLES(TICKS)) csi_contour_interp_i (.mclk_in(mclk_in), .rst_in(rst_in),
        .rec_valid_in(rec_valid), .rec_in(rec), .rec_ready_out(rec_ready_out), .resp_valid_out(resp_valid_out),
        .resp_char_out(resp_char_out), .contour_active_out(contour_active_out),
        .contour_axis_select_out(contour_axis_select_out), .point_valid_out(point_valid_out),
        .seg_done_out(seg_done_out), .axis_pos_out(axis_pos_out));
    csi_src_model csi_src_model_i (.mclk_in(mclk_in), .rec_ready_in(rec_ready_out), .rec_valid_out(rec_valid),
        .rec_out(rec));

    ////////////////////////////////////////////////////////////
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp)
        begin
            fails++;
            $display("BAD %s expected %0h seen %0h", what, exp, seen);
        end
    endtask : chk

    task automatic end_of_test;
        $display("checks %0d mismatches %0d", checked, fails);
        if (fails == 0 && checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : end_of_test

    task automatic put(input csi_row_s w);
        csi_pkg::csi_rec_s r;
        r = '0;
        r.sel_load = 1'b1;
        r.axis_sel = w.sel;
        r.code_load = w.cl;
        r.code = 4'(w.code);
        r.wait_done = w.wt;
        for (int a = 0; a < 8; a++)
            r.incr[a] = a[0] ? 16'(w.a1) : 16'(w.a0);
        csi_src_model_i.send(r, 1);
    endtask : put

    task automatic good(input csi_row_s w);
        csi_row_s e;
        lc = w.cl ? w.code : lc;
        e = w;
        e.code = lc;
        segq.push_back(e);
        put(w);
    endtask : good

    task automatic bad(input csi_row_s w);
        put(w);
        chk("resp_valid", resp_valid_out, 1); // bad answered
        chk("resp_char", resp_char_out, 8'h3F); // question mark
    endtask : bad

    task automatic drain;
        for (int i = 0; i < 3000 && segq.size() != 0; i++) @(negedge mclk_in);
        chk("segments left", segq.size(), 0); // all run
    endtask : drain

    ////////////////////////////////////////////////////////////
    // Point checker against queued segments
    always @(negedge mclk_in)
    begin
        gap = gap + 1;
        if (point_valid_out === 1'b1)
        begin
            pts = pts + 1;
            streak = (gap == TICKS) ? streak + 1 : 0;
            gap = 0;
            chk("point queued", segq.size() != 0, 1); // no data no points
            if (segq.size() != 0)
            begin
                cur = segq[0];
                j = j + 1;
                for (int a = 0; a < 8; a++)
                    chk("axis_pos", axis_pos_out[a], base[a] + (cur.sel[a] ? ((a % 2 ? cur.a1 : cur.a0) * j) >>> cur.code : 0)); // exact
                chk("seg_done", seg_done_out, j == (1 << cur.code)); // duration
                if (j == (1 << cur.code))
                begin
                    for (int a = 0; a < 8; a++)
                        base[a] += cur.sel[a] ? (a % 2 ? cur.a1 : cur.a0) : 0;
                    j = 0;
                    void'(segq.pop_front());
                end
            end
        end
    end

    always @(posedge mclk_in)
    begin
        cyc++;
        if (cyc == 8000)
        begin
            fails++;
            end_of_test;
        end
    end

    ////////////////////////////////////////////////////////////
    initial
    begin
        rows = '{'{8'h03, 1, 1, 1, 5, -3}, '{8'h01, 1, 2, 1, 48, 0}, '{8'hFF, 1, 3, 1, 240, -240},
            '{8'h81, 1, 4, 1, 48, 7}, '{8'h02, 0, 0, 1, -32000, 32000}, '{8'hAA, 1, 5, 1, -1, 1},
            '{8'h55, 1, 6, 1, 100, -100}, '{8'h0F, 1, 7, 1, 3, -5}, '{8'hF0, 1, 8, 1, -32000, 31999}};
        repeat (20) @(negedge mclk_in);
        chk("ready in reset", rec_ready_out, 0); // intake closed
        chk("pos in reset", axis_pos_out[0], 0); // no motion
        rst_in = 1'b0;
        repeat (2) @(negedge mclk_in);
        foreach (rows[i])
        begin
            good(rows[i]);
            chk("ready while waiting", rec_ready_out, 0); // wait blocks
            chk("active", contour_active_out, 1); // contouring
            chk("select", contour_axis_select_out, rows[i].sel); // axis set
        end
        drain;
        $display("test rows done");
        n = pts;
        repeat (20) @(negedge mclk_in);
        chk("idle points", pts, n); // hold
        chk("idle active", contour_active_out, 1); // hold
        $display("test idle done");
        bad('{8'h01, 1, 9, 0, 1, 1});
        bad('{8'h01, 1, 2, 0, 32001, 0});
        bad('{8'h00, 1, 2, 0, 1, 1});
        bad('{8'h01, 1, 0, 0, 5, 5});
        $display("test bad records done");
        for (int i = 0; i < 3; i++)
            good('{8'h03, 1, 2, 0, 7 + i, -9});
        chk("ready when full", rec_ready_out, 0); // two records pending
        drain;
        chk("gapless streak", streak >= 11, 1); // next tick start
        $display("test burst done");
        put('{8'h03, 1, 0, 0, 0, 0});
        repeat (2) @(negedge mclk_in);
        chk("exit active", contour_active_out, 0); // leave mode
        chk("exit select", contour_axis_select_out, 0); // leave mode
        $display("test exit done");
        rst_in = 1'b1;
        @(negedge mclk_in);
        chk("pos in mid reset", axis_pos_out[4], 0); // positions cleared
        chk("ready in mid reset", rec_ready_out, 0); // intake closed
        rst_in = 1'b0;
        repeat (2) @(negedge mclk_in);
        chk("ready after reset", rec_ready_out, 1); // intake open
        bad('{8'h01, 0, 0, 0, 3, 3});
        chk("active after reset", contour_active_out, 0); // no code kept
        $display("test reset done");
        end_of_test;
    end
endmodule : csi_contour_interp_tb
